// >>> ccst_pkg.sv
// constants, types and timing for the image sensor clock sequencer
// Summary of operation
// - dump gate low, pulsed high only to discard
// - left-only readout swaps right phases one, two
// - normal mode image period 20us, pulse 8.665us
// - inverted mode period 100us, first interval 50us
// - image phases overlap 2us, under 0.2 period
// - at least 3us image stop to register start
// - at least 1us register stop to image start
// - register period at least 300ns, pixel-rate set
// - reset gate falls 0.5 period before phase three
// - no upper bound on periods or delays; 16-bit counters here cap them
package ccst_pkg;

   // ---------------------------------------------------------------
   // clock and timing figures
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int NRM_PER_NS    = 20000;
   localparam int INV_PER_NS    = 100000;
   localparam int INV_ST0_NS    = 50000;
   localparam int IMG_OVL_NS    = 2000;
   localparam int TDIR_NS       = 5000;
   localparam int TDRI_NS       = 2000;
   localparam int REG_PER_NS    = 400;
   localparam int RST_MIN_NS    = 30;
   localparam int REG_OVL_NS    = 20;
   localparam int DUMP_NS       = 2000;

   // least times round up to whole cycles
   localparam int NRM_PER_CYC = (NRM_PER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int INV_PER_CYC = (INV_PER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int INV_ST0_CYC = (INV_ST0_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int IMG_OVL_CYC = (IMG_OVL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TDIR_CYC    = (TDIR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TDRI_CYC    = (TDRI_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int REG_PER_CYC = (REG_PER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RST_MIN_CYC = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int REG_OVL_CYC = (REG_OVL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DUMP_CYC    = (DUMP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // ---------------------------------------------------------------
   // widths and step encoding
   // ---------------------------------------------------------------
   // wide counters leave room for long periods, but each is capped by its 16-bit width
   localparam int CNT_W     = 16;
   localparam int LINE_W    = 12;
   localparam int STEP_LAST = 5;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_IMG    = 6'h02,
      ST_GAP_IR = 6'h04,
      ST_READ   = 6'h08,
      ST_DUMP   = 6'h10,
      ST_GAP_RI = 6'h20
   } ccst_state_t;

   typedef struct packed {
      logic              inverted_low_dark_operation;
      logic              left_only;
      logic [LINE_W-1:0] lines;
      logic [LINE_W-1:0] dump_lines;
      logic [LINE_W-1:0] pixels;
   } ccst_cfg_t;

   typedef struct packed {
      logic image_phase_one;
      logic image_phase_two;
      logic image_phase_three;
      logic left_register_phase_one;
      logic left_register_phase_two;
      logic register_phase_three;
      logic right_register_phase_one;
      logic right_register_phase_two;
      logic reset_gate;
      logic summing_node_gate;
      logic charge_dump_gate;
   } ccst_pins_t;

endpackage

// >>> ccst_sequencer.sv
// clock sequencer driving a two-output full-frame image sensor
`timescale 1ns/100ps
module ccst_sequencer #(
   parameter logic [15:0] INV_PERIOD_CYC = 16'(ccst_pkg::INV_PER_CYC),
   parameter logic [15:0] INV_FIRST_CYC  = 16'(ccst_pkg::INV_ST0_CYC),
   parameter logic [15:0] REG_PERIOD_CYC = 16'(ccst_pkg::REG_PER_CYC)
) (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                reset_n,
   // frame request
   input  wire logic                frame_start,
   input  wire ccst_pkg::ccst_cfg_t frame_cfg,
   // sensor clock drives
   output ccst_pkg::ccst_pins_t     sensor_pins,
   // status toward the sampling logic
   output logic                     busy,
   output logic                     pixel_strobe,
   output logic                     line_done,
   output logic                     frame_done
);

   // ---------------------------------------------------------------
   // derived timing
   // ---------------------------------------------------------------
   localparam logic [15:0] OVL_I  = 16'(ccst_pkg::IMG_OVL_CYC);
   localparam logic [15:0] N_SGL  = 16'(ccst_pkg::NRM_PER_CYC / 3 - ccst_pkg::IMG_OVL_CYC);
   localparam logic [15:0] A_SGL  = INV_PERIOD_CYC / 16'd3 - OVL_I;
   localparam logic [15:0] TR3    = REG_PERIOD_CYC / 16'd3;
   localparam logic [15:0] RW_T   = REG_PERIOD_CYC / 16'd10;
   localparam logic [15:0] RMIN   = 16'(ccst_pkg::RST_MIN_CYC);
   localparam logic [15:0] RW     = (RW_T > RMIN) ? RW_T : RMIN;
   localparam logic [15:0] E3     = RW + REG_PERIOD_CYC / 16'd2;
   localparam logic [15:0] OVL_R  = 16'(ccst_pkg::REG_OVL_CYC);
   localparam logic [15:0] WLEN   = TR3 + OVL_R;
   localparam logic [15:0] S1     = E3 - OVL_R;
   localparam logic [15:0] S2     = (S1 + TR3) % REG_PERIOD_CYC;
   localparam logic [15:0] S3     = (S1 + TR3 + TR3) % REG_PERIOD_CYC;
   localparam logic [15:0] TDIR   = 16'(ccst_pkg::TDIR_CYC);
   localparam logic [15:0] TDRI   = 16'(ccst_pkg::TDRI_CYC);
   localparam logic [15:0] TDUMP  = 16'(ccst_pkg::DUMP_CYC);
   localparam logic [2:0]  SLAST  = 3'(ccst_pkg::STEP_LAST);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   ccst_pkg::ccst_state_t       state_r, state_nxt;
   ccst_pkg::ccst_cfg_t         cfg_r, cfg_nxt;
   ccst_pkg::ccst_pins_t        pins_r, pins_nxt;
   logic [ccst_pkg::CNT_W-1:0]  cnt_r, cnt_nxt;
   logic [ccst_pkg::CNT_W-1:0]  pc_r, pc_nxt;
   logic [2:0]                  step_r, step_nxt;
   logic [ccst_pkg::LINE_W-1:0] pix_r, pix_nxt;
   logic [ccst_pkg::LINE_W:0]   line_r, line_nxt;
   logic                        busy_r, busy_nxt;
   logic                        strobe_r, strobe_nxt;
   logic                        ldone_r, ldone_nxt;
   logic                        fdone_r, fdone_nxt;

   // cyclic window test inside one pixel period
   function automatic logic in_win(input logic [15:0] pc, input logic [15:0] s);
      logic [15:0] d;
      d = (pc >= s) ? (pc - s) : (pc + REG_PERIOD_CYC - s);
      return d < WLEN;
   endfunction

   // length of an image step, minus one for the down counter
   function automatic logic [15:0] step_len(input logic [2:0] st, input logic inv);
      logic [15:0] l;
      if (st[0]) begin
         l = OVL_I;
      end else if (inv) begin
         l = (st == 3'd0) ? INV_FIRST_CYC : A_SGL;
      end else begin
         l = N_SGL;
      end
      return l - 16'd1;
   endfunction

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      logic [ccst_pkg::LINE_W:0] total;
      logic                      r1;
      logic                      r2;
      total      = {1'b0, cfg_r.lines} + {1'b0, cfg_r.dump_lines};
      r1         = 1'b0;
      r2         = 1'b0;
      state_nxt  = state_r;
      cfg_nxt    = cfg_r;
      cnt_nxt    = cnt_r;
      pc_nxt     = pc_r;
      step_nxt   = step_r;
      pix_nxt    = pix_r;
      line_nxt   = line_r;
      strobe_nxt = 1'b0;
      ldone_nxt  = 1'b0;
      fdone_nxt  = 1'b0;
      // image area rests with phase three high so the output keeps its dc level;
      // register clocks rest low so no phase three fall comes without a reset pulse
      pins_nxt                   = '0;
      pins_nxt.image_phase_three = 1'b1;

      case (state_r)
         ccst_pkg::ST_IDLE: begin
            if (frame_start &&
                ({1'b0, frame_cfg.lines} + {1'b0, frame_cfg.dump_lines}) != '0) begin
               cfg_nxt   = frame_cfg;
               line_nxt  = '0;
               step_nxt  = '0;
               cnt_nxt   = step_len(3'd0, frame_cfg.inverted_low_dark_operation);
               state_nxt = ccst_pkg::ST_IMG;
            end
         end
         ccst_pkg::ST_IMG: begin
            // six steps: 3, 3+1, 1, 1+2, 2, 2+3; overlap steps are the odd ones
            case (step_r)
               3'd0: pins_nxt.image_phase_three = 1'b1;
               3'd1: pins_nxt.image_phase_one   = 1'b1;
               3'd2: begin
                  pins_nxt.image_phase_three = 1'b0;
                  pins_nxt.image_phase_one   = 1'b1;
               end
               3'd3: begin
                  pins_nxt.image_phase_three = 1'b0;
                  pins_nxt.image_phase_one   = 1'b1;
                  pins_nxt.image_phase_two   = 1'b1;
               end
               3'd4: begin
                  pins_nxt.image_phase_three = 1'b0;
                  pins_nxt.image_phase_two   = 1'b1;
               end
               default: pins_nxt.image_phase_two = 1'b1;
            endcase
            if (cnt_r == '0) begin
               if (step_r == SLAST) begin
                  cnt_nxt   = TDIR - 16'd1;
                  state_nxt = ccst_pkg::ST_GAP_IR;
               end else begin
                  step_nxt = step_r + 3'd1;
                  cnt_nxt  = step_len(step_r + 3'd1, cfg_r.inverted_low_dark_operation);
               end
            end else begin
               cnt_nxt = cnt_r - 16'd1;
            end
         end
         ccst_pkg::ST_GAP_IR: begin
            if (cnt_r != '0) begin
               cnt_nxt = cnt_r - 16'd1;
            end else if (line_r < {1'b0, cfg_r.dump_lines}) begin
               cnt_nxt   = TDUMP - 16'd1;
               state_nxt = ccst_pkg::ST_DUMP;
            end else if (cfg_r.pixels == '0) begin
               cnt_nxt   = TDRI - 16'd1;
               state_nxt = ccst_pkg::ST_GAP_RI;
            end else begin
               pc_nxt    = '0;
               pix_nxt   = '0;
               state_nxt = ccst_pkg::ST_READ;
            end
         end
         ccst_pkg::ST_READ: begin
            r1 = in_win(pc_r, S1);
            r2 = in_win(pc_r, S2);
            pins_nxt.left_register_phase_one = r1;
            pins_nxt.left_register_phase_two = r2;
            // swapping the right pair sends every pixel to the left amplifier
            pins_nxt.right_register_phase_one = cfg_r.left_only ? r2 : r1;
            pins_nxt.right_register_phase_two = cfg_r.left_only ? r1 : r2;
            pins_nxt.register_phase_three = in_win(pc_r, S3);
            pins_nxt.summing_node_gate    = in_win(pc_r, S3);
            // reset gate falls half a period before the pixel strobe, 38 cycles before phase three falls
            pins_nxt.reset_gate = (pc_r < RW);
            strobe_nxt = (pc_r == E3);
            if (pc_r == REG_PERIOD_CYC - 16'd1) begin
               pc_nxt  = '0;
               pix_nxt = pix_r + 12'd1;
               if (pix_r == cfg_r.pixels - 12'd1) begin
                  cnt_nxt   = TDRI - 16'd1;
                  state_nxt = ccst_pkg::ST_GAP_RI;
               end
            end else begin
               pc_nxt = pc_r + 16'd1;
            end
         end
         ccst_pkg::ST_DUMP: begin
            pins_nxt.charge_dump_gate = 1'b1;
            if (cnt_r == '0) begin
               cnt_nxt   = TDRI - 16'd1;
               state_nxt = ccst_pkg::ST_GAP_RI;
            end else begin
               cnt_nxt = cnt_r - 16'd1;
            end
         end
         ccst_pkg::ST_GAP_RI: begin
            if (cnt_r != '0) begin
               cnt_nxt = cnt_r - 16'd1;
            end else begin
               ldone_nxt = 1'b1;
               line_nxt  = line_r + 13'd1;
               if (line_r == total - 13'd1) begin
                  fdone_nxt = 1'b1;
                  state_nxt = ccst_pkg::ST_IDLE;
               end else begin
                  step_nxt  = '0;
                  cnt_nxt   = step_len(3'd0, cfg_r.inverted_low_dark_operation);
                  state_nxt = ccst_pkg::ST_IMG;
               end
            end
         end
         default: state_nxt = ccst_pkg::ST_IDLE;
      endcase
      busy_nxt = (state_nxt != ccst_pkg::ST_IDLE);
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r  <= ccst_pkg::ST_IDLE;
         cfg_r    <= '0;
         pins_r   <= '0;
         cnt_r    <= '0;
         pc_r     <= '0;
         step_r   <= '0;
         pix_r    <= '0;
         line_r   <= '0;
         busy_r   <= 1'b0;
         strobe_r <= 1'b0;
         ldone_r  <= 1'b0;
         fdone_r  <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         cfg_r    <= cfg_nxt;
         pins_r   <= pins_nxt;
         cnt_r    <= cnt_nxt;
         pc_r     <= pc_nxt;
         step_r   <= step_nxt;
         pix_r    <= pix_nxt;
         line_r   <= line_nxt;
         busy_r   <= busy_nxt;
         strobe_r <= strobe_nxt;
         ldone_r  <= ldone_nxt;
         fdone_r  <= fdone_nxt;
      end
   end

   assign sensor_pins  = pins_r;
   assign busy         = busy_r;
   assign pixel_strobe = strobe_r;
   assign line_done    = ldone_r;
   assign frame_done   = fdone_r;

endmodule

// >>> ccst_asserts.sv
// port assertions for the image sensor clock sequencer
`timescale 1ns/100ps
module ccst_asserts #(
   parameter logic [15:0] INV_PERIOD_CYC = 16'h05dc,
   parameter logic [15:0] INV_FIRST_CYC  = 16'h0032,
   parameter logic [15:0] REG_PERIOD_CYC = 16'h0050
) (
   // clock and reset
   input wire logic                 sys_clk,
   input wire logic                 reset_n,
   // frame request
   input wire logic                 frame_start,
   input wire ccst_pkg::ccst_cfg_t  frame_cfg,
   // drives and status
   input wire ccst_pkg::ccst_pins_t sensor_pins,
   input wire logic                 busy,
   input wire logic                 pixel_strobe,
   input wire logic                 line_done,
   input wire logic                 frame_done
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // ---------------------------------------------------------------
   // saturating ages since image, register, strobe, reset gate events
   // ---------------------------------------------------------------
   ccst_pkg::ccst_pins_t p_r;
   logic [15:0]          age_r [5];
   logic [4:0]           evt;

   assign evt[0] = sensor_pins[10:9] != p_r[10:9];
   assign evt[1] = sensor_pins[7:2] != p_r[7:2];
   assign evt[2] = pixel_strobe;
   assign evt[3] = p_r.reset_gate && !sensor_pins.reset_gate;
   assign evt[4] = !sensor_pins.image_phase_one;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         p_r <= '0;
         for (int i = 0; i < 5; i++) age_r[i] <= 16'hffff;
      end else begin
         p_r <= sensor_pins;
         for (int i = 0; i < 5; i++)
            age_r[i] <= evt[i] ? 16'h0 : age_r[i] + 16'(age_r[i] != 16'hffff);
      end
   end

   sequence s_last_line;
      line_done && !busy;
   endsequence

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_dump_not_read: assert property (sensor_pins.charge_dump_gate |-> busy && !sensor_pins.reset_gate)
      else $error("dump gate high outside a dump");
   a_right_phase_map: assert property (busy |-> (frame_cfg.left_only ?
      sensor_pins[4:3] == {sensor_pins[6], sensor_pins[7]} : sensor_pins[4:3] == sensor_pins[7:6]))
      else $error("right register phases wired wrong");
   a_image_width_min: assert property ($fell(sensor_pins.image_phase_one) &&
      !frame_cfg.inverted_low_dark_operation |-> age_r[4] >= 16'd1000)
      else $error("image pulse narrower than 5 us");
   a_image_overlap: assert property ($fell(sensor_pins.image_phase_three) |->
      sensor_pins.image_phase_one && $past(sensor_pins.image_phase_one, 399))
      else $error("image phases do not overlap 2 us");
   a_image_to_reg: assert property (evt[1] |-> age_r[0] >= 16'd599)
      else $error("register clocks start too soon");
   a_reg_to_image: assert property (evt[0] |-> age_r[1] >= 16'd199)
      else $error("image clocks start too soon");
   a_pixel_period: assert property (pixel_strobe |-> age_r[2] >= 16'd59)
      else $error("pixel period under 300 ns");
   a_reset_lead: assert property ($fell(sensor_pins.register_phase_three) |->
      age_r[3] >= 16'd5 && age_r[3] < REG_PERIOD_CYC * 16'd4 / 16'd5)
      else $error("reset gate lead out of range");
   a_summing_follows: assert property (sensor_pins.summing_node_gate ==
      sensor_pins.register_phase_three)
      else $error("summing gate not with phase three");
   a_frame_end: assert property (frame_done |-> s_last_line)
      else $error("frame end without last line");
endmodule

// >>> ccst_sensor_model.sv
// behavioural model of the two-output image sensor
`timescale 1ns/100ps
module ccst_sensor_model (
   // drives, sampled on the bench clock since the sensor has none
   input  wire logic                 sys_clk,
   input  wire ccst_pkg::ccst_pins_t sensor_pins,
   // observed behaviour
   output logic                      dc_restore,
   output logic [15:0]               shifts,
   output logic [15:0]               dumps
);
   ccst_pkg::ccst_pins_t prev_r    = '0;
   logic [15:0]          shift_cnt = 16'h0;
   logic [15:0]          dump_cnt  = 16'h0;

   assign dc_restore = sensor_pins.image_phase_three;
   assign shifts     = shift_cnt;
   assign dumps      = dump_cnt;
   always @(posedge sys_clk) begin
      // one pixel leaves per phase three fall
      if (prev_r.register_phase_three && !sensor_pins.register_phase_three)
         shift_cnt <= shift_cnt + 16'h1;
      if (!prev_r.charge_dump_gate && sensor_pins.charge_dump_gate)
         dump_cnt <= dump_cnt + 16'h1;
      prev_r <= sensor_pins;
   end
endmodule

// >>> ccst_tb.sv
// self-checking bench for the image sensor clock sequencer
`timescale 1ns/100ps
bind ccst_sequencer ccst_asserts #(
   .INV_PERIOD_CYC(INV_PERIOD_CYC),
   .INV_FIRST_CYC (INV_FIRST_CYC),
   .REG_PERIOD_CYC(REG_PERIOD_CYC)
) u_ccst_asserts (
   .sys_clk(sys_clk), .reset_n(reset_n), .frame_start(frame_start),
   .frame_cfg(frame_cfg), .sensor_pins(sensor_pins), .busy(busy),
   .pixel_strobe(pixel_strobe), .line_done(line_done), .frame_done(frame_done)
);

module tb;
   logic                 sys_clk     = 1'b0;
   logic                 reset_n     = 1'b0;
   logic                 frame_start = 1'b0;
   ccst_pkg::ccst_cfg_t  frame_cfg   = '0;
   ccst_pkg::ccst_pins_t sensor_pins;
   logic                 busy, pixel_strobe, line_done, frame_done, dc_restore;
   logic [15:0]          shifts, dumps;
   logic [15:0]          n_line      = 16'h0;
   logic [15:0]          n_pix       = 16'h0;
   int                   num_errors  = 0;
   int                   samples_checked = 0;

   always #2.5 sys_clk = ~sys_clk;

   // shortened inverted-mode counts keep the run brief
   ccst_sequencer #(.INV_PERIOD_CYC(16'h05dc), .INV_FIRST_CYC(16'h0032),
      .REG_PERIOD_CYC(16'h0050)) u_ccst_sequencer (
      .sys_clk(sys_clk), .reset_n(reset_n), .frame_start(frame_start),
      .frame_cfg(frame_cfg), .sensor_pins(sensor_pins), .busy(busy),
      .pixel_strobe(pixel_strobe), .line_done(line_done), .frame_done(frame_done));
   ccst_sensor_model u_ccst_sensor_model (.sys_clk(sys_clk), .sensor_pins(sensor_pins),
      .dc_restore(dc_restore), .shifts(shifts), .dumps(dumps));

   always @(posedge sys_clk) if (line_done === 1'b1) n_line <= n_line + 16'h1;
   always @(posedge sys_clk) if (pixel_strobe === 1'b1) n_pix <= n_pix + 16'h1;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [15:0] exp_shifts(ccst_pkg::ccst_cfg_t c, bit a);
      return a ? 16'(c.pixels) * 16'(c.lines) : 16'h0;
   endfunction

   // one frame; a second start mid-frame must be ignored
   task automatic run_frame(input ccst_pkg::ccst_cfg_t cfg, input bit acc);
      logic [15:0] s0, d0, l0, p0;
      int n;
      s0 = shifts;
      d0 = dumps;
      l0 = n_line;
      p0 = n_pix;
      @(negedge sys_clk);
      frame_cfg = cfg;
      frame_start = 1'b1;
      @(negedge sys_clk);
      frame_start = 1'b0;
      check({15'h0, busy}, {15'h0, acc});
      n = 0;
      while (acc && frame_done !== 1'b1 && n < 20000) begin
         @(negedge sys_clk);
         frame_start = (n == 50);
         n++;
      end
      check(16'(n == 20000), 16'h0);
      @(negedge sys_clk);
      check(shifts - s0, exp_shifts(cfg, acc));
      check(n_pix - p0, exp_shifts(cfg, acc));
      check(dumps - d0, acc ? 16'(cfg.dump_lines) : 16'h0);
      check(n_line - l0, acc ? 16'(cfg.lines) + 16'(cfg.dump_lines) : 16'h0);
      check({15'h0, busy}, 16'h0);
      check({15'h0, dc_restore}, 16'h1);
   endtask

   initial begin
      ccst_pkg::ccst_cfg_t c;
      void'($urandom(35857));
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      reset_n = 1'b1;
      c = '0;
      run_frame(c, 1'b0);
      // every mode and wiring, random line mix and pixel count, zero pixels when m is 2
      for (int m = 0; m < 4; m++) begin
         c.inverted_low_dark_operation = m[1];
         c.left_only = m[0];
         c.lines = 12'($urandom_range(0, 1));
         c.dump_lines = (c.lines == 12'h0) ? 12'h001 : 12'($urandom_range(0, 1));
         c.pixels = (m == 2) ? 12'h000 : 12'($urandom_range(1, 6));
         run_frame(c, 1'b1);
      end
      stop_test();
   end

   initial begin
      #400000;
      num_errors++;
      stop_test();
   end
endmodule
